/* rtl/pacs_top.sv */
`timescale 1ns/1ps
module pacs_top
    import pacs_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        tx_rx_select_in,
    input  wire logic        pll_lock_in,
    input  wire logic        supply_low_in,
    output logic             amp_enable_out,
    output logic             power_step_pin_o,
    output logic             power_step_pin_oe,
    output logic             signal_strength_probe,
    // sequencing events
    output logic             recal_start,
    output logic             rx_mode,
    output logic             cmp_tick
);

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic       sel_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle levels: supply ok, pll locked, select high
            s1_q <= 3'h3;
            s2_q <= 3'h3;
        end else begin
            s1_q <= {supply_low_in, pll_lock_in, tx_rx_select_in};
            s2_q <= s1_q;
        end
    end

    logic sel;
    logic sel_rise;
    logic sel_fall;
    assign sel      = s2_q[0];
    assign sel_rise = sel & ~sel_prev_q;
    assign sel_fall = ~sel & sel_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_prev_q <= 1'b1;
        end else begin
            sel_prev_q <= sel;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [5:0] cfg0_q;
    logic [2:0] probe_q;
    logic       wr_en;
    logic       rd_en;
    logic       addr_ok;

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == CFG0_ADDR) || (a == TEST_ADDR) ||
                   (a == STAT_ADDR);
    endfunction

    assign pready  = 1'b1;
    assign addr_ok = addr_hit(paddr);
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign pslverr = psel & penable & ~addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg0_q <= CFG0_RST;
        end else if (wr_en && paddr == CFG0_ADDR) begin
            cfg0_q <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            probe_q <= PROBE_RST;
        end else if (wr_en && paddr == TEST_ADDR) begin
            probe_q <= pwdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // reference divider
    // ----------------------------------------------------------------
    pacs_ref_div u_div (
        .pclk               (pclk),
        .presetn            (presetn),
        .divide_select_bit0 (cfg0_q[DIV_SEL_POS]),
        .cmp_tick           (cmp_tick)
    );

    // ----------------------------------------------------------------
    // slot timer
    // ----------------------------------------------------------------
    // one counter serves both directions; it restarts on every edge
    logic [CNT_W-1:0] cnt_q;
    logic             tx_slot;
    assign tx_slot = ~sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (sel_rise || sel_fall) begin
            cnt_q <= '0;
        end else if (cnt_q != {CNT_W{1'b1}}) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    logic pa_time_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_time_q <= 1'b0;
        end else if (sel_rise) begin
            pa_time_q <= 1'b0;
        end else if (tx_slot && cnt_q == CNT_W'(PA_ON_CYC - 1)) begin
            pa_time_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recal_start <= 1'b0;
        end else begin
            recal_start <= sel && !sel_rise &&
                           cnt_q == CNT_W'(RECAL_CYC - 2);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_mode <= 1'b0;
        end else if (!sel) begin
            rx_mode <= 1'b0;
        end else if (!sel_rise && cnt_q == CNT_W'(RX_CYC - 2)) begin
            rx_mode <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // fault latches
    // ----------------------------------------------------------------
    pacs_fault_t flt_q;
    logic        lock_bad;
    logic        supply_bad;
    assign lock_bad   = ~s2_q[1];
    assign supply_bad = s2_q[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt_q <= '0;
        end else if (sel_rise) begin
            flt_q <= '0;
        end else if (tx_slot) begin
            flt_q.lock_fault   <= flt_q.lock_fault | lock_bad;
            flt_q.supply_fault <= flt_q.supply_fault | supply_bad;
        end
    end

    // drop is combinational on the synced edge: well under 0.1us
    assign amp_enable_out = pa_time_q & tx_slot & ~lock_bad & ~supply_bad
                          & ~flt_q.lock_fault
                          & ~flt_q.supply_fault;

    // ----------------------------------------------------------------
    // power step pin
    // ----------------------------------------------------------------
    logic pstep_q;
    logic probe_on;
    assign probe_on = (probe_q != 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pstep_q <= 1'b0;
        end else if (sel_fall) begin
            pstep_q <= cfg0_q[PSTEP_POS];
        end
    end

    // probe use releases the pin so analog paths can observe it
    assign power_step_pin_o      = 1'b0;
    assign power_step_pin_oe     = pstep_q & ~probe_on;
    assign signal_strength_probe = probe_on;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    pacs_stat_t stat;
    assign stat = '{amp_en: amp_enable_out, recal: recal_start,
                    rx_mode: rx_mode, probe_on: probe_on};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                CFG0_ADDR: prdata <= {26'h0, cfg0_q};
                TEST_ADDR: prdata <= {29'h0, probe_q};
                STAT_ADDR: prdata <= {25'h0, pstep_q, flt_q, stat};
                default:   prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pa_rise_delay: assert property (
        $rose(pa_time_q) |-> $past(cnt_q) == CNT_W'(PA_ON_CYC - 1)
    ) else $error("amp enable timer wrong");
    a_recal_delay: assert property (
        recal_start |-> sel && cnt_q == CNT_W'(RECAL_CYC - 1)
    ) else $error("recal start at wrong time");
    a_rx_entry: assert property (
        $rose(rx_mode) |-> cnt_q == CNT_W'(RX_CYC - 1)
    ) else $error("rx mode entry wrong");
    a_pa_drop: assert property (
        sel_rise |-> !amp_enable_out
    ) else $error("amp enable not dropped");
    a_fault_hold: assert property (
        (lock_bad || supply_bad) |-> !amp_enable_out
    ) else $error("amp enable during fault");
    a_latch_slot: assert property (
        (tx_slot && flt_q != '0) |=> (flt_q != '0) || sel_rise
    ) else $error("fault latch lost in slot");
    a_latch_clear: assert property (
        sel_rise |=> flt_q == '0
    ) else $error("fault latch not cleared");
    a_step_hold: assert property (
        !sel_fall |=> $stable(pstep_q)
    ) else $error("step pin changed off edge");
    a_probe_free: assert property (
        probe_on |-> !power_step_pin_oe
    ) else $error("pin driven in probe mode");

endmodule // pacs_top

/* rtl/pacs_pkg.sv */
package pacs_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned T_PA_ON_NS    = 62500;
    localparam int unsigned T_RECAL_NS    = 6500;
    localparam int unsigned T_RX_NS       = 70000;
    localparam int unsigned T_PA_OFF_NS   = 100;
    // nearest whole cycle, except PA_OFF_CYC which rounds down
    localparam int unsigned PA_ON_CYC =
        (T_PA_ON_NS * 1000 + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
    localparam int unsigned RECAL_CYC =
        (T_RECAL_NS * 1000 + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
    localparam int unsigned RX_CYC =
        (T_RX_NS * 1000 + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
    localparam int unsigned PA_OFF_CYC =
        (T_PA_OFF_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 14;

    // ----------------------------------------------------------------
    // reference divider
    // ----------------------------------------------------------------
    localparam logic [3:0] DIV_LO = 4'h6;
    localparam logic [3:0] DIV_HI = 4'hc;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] CFG0_ADDR   = 12'h000;
    localparam logic [11:0] TEST_ADDR   = 12'h004;
    localparam logic [11:0] STAT_ADDR   = 12'h008;
    localparam int unsigned DIV_SEL_POS = 1;
    localparam int unsigned PSTEP_POS   = 5;
    localparam logic [5:0]  CFG0_RST    = 6'h00;
    localparam logic [2:0]  PROBE_RST   = 3'h0;

    typedef struct packed {
        logic lock_fault;
        logic supply_fault;
    } pacs_fault_t;

    typedef struct packed {
        logic amp_en;
        logic recal;
        logic rx_mode;
        logic probe_on;
    } pacs_stat_t;

endpackage

/* rtl/pacs_ref_div.sv */
`timescale 1ns/1ps
module pacs_ref_div
    import pacs_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic divide_select_bit0,
    // output
    output logic      cmp_tick
);

    logic [3:0] cnt_q;
    logic [3:0] lim;

    assign lim = divide_select_bit0 ? DIV_HI : DIV_LO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= lim - 4'h1) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    assign cmp_tick = (cnt_q == 4'h0);

endmodule // pacs_ref_div

/* sim/pacs_pa_model.sv */
`timescale 1ns/1ps
module pacs_pa_model (
    // device pins
    input  wire logic amp_enable_out,
    input  wire logic power_step_pin_o,
    input  wire logic power_step_pin_oe,
    // resolved lines
    output logic      power_step_wire,
    output logic      pa_powered
);
    // resistor network pulls the released step line high
    assign power_step_wire = power_step_pin_oe ? power_step_pin_o : 1'b1;
    // amplifier is powered only by a high enable level
    assign pa_powered      = (amp_enable_out === 1'b1);
endmodule // pacs_pa_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import pacs_pkg::*;
    // --------
    // signals
    // --------
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } pacs_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, tx_rx_select_in = 1'b1;
    logic        pll_lock_in = 1'b1, supply_low_in = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, amp_enable_out, power_step_pin_o;
    logic        power_step_pin_oe, signal_strength_probe, recal_start;
    logic        rx_mode, cmp_tick, power_step_wire, er, pa_powered;
    int          n_errors = 0, n_tests = 0, n, m, k;
    pacs_row_t   rows [5] = '{
        '{CFG0_ADDR, 32'hffffffff, 32'h0000003f, 1'b0},
        '{TEST_ADDR, 32'hffffffff, 32'h00000007, 1'b0},
        '{TEST_ADDR, 32'h00000000, 32'h00000000, 1'b0},
        '{CFG0_ADDR, 32'h00000000, 32'h00000000, 1'b0},
        '{12'h00c,   32'h0000002a, 32'h00000000, 1'b1}};

    always #4 pclk = ~pclk;

    pacs_top u_pacs_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tx_rx_select_in, .pll_lock_in,
        .supply_low_in, .amp_enable_out, .power_step_pin_o,
        .power_step_pin_oe, .signal_strength_probe, .recal_start,
        .rx_mode, .cmp_tick);
    pacs_pa_model u_pacs_pa_model (
        .amp_enable_out, .power_step_pin_o, .power_step_pin_oe,
        .power_step_wire, .pa_powered);

    // --------
    // tasks
    // --------
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return amp_enable_out;
            1: return recal_start;
            2: return rx_mode;
            default: return cmp_tick;
        endcase
    endfunction

    task automatic wait_on(input int w, input logic v, input int lim,
                           output int cnt);
        cnt = 0;
        do begin
            @(posedge pclk);
            #1;
            cnt++;
        end while (pick(w) !== v && cnt < lim);
    endtask

    task automatic set_sel(input logic v);
        @(posedge pclk);
        tx_rx_select_in <= v;
    endtask

    // --------
    // sequence
    // --------
    initial begin
        #(8 * 90000);
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk(amp_enable_out === 1'b0, "amp low in reset");
        apb(1'b0, CFG0_ADDR, 32'h0, rd, er);
        chk(rd === 32'h0, "cfg0 reset value");
        apb(1'b0, TEST_ADDR, 32'h0, rd, er);
        chk(rd === 32'h0, "probe reset value");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata, rd, er);
            apb(1'b0, rows[i].addr, 32'h0, rd, er);
            chk(rd === rows[i].rdata && er === rows[i].err, "reg row");
        end
        apb(1'b1, TEST_ADDR, 32'h4, rd, er);
        #1 chk(signal_strength_probe === 1'b1, "probe on");
        apb(1'b1, TEST_ADDR, 32'h0, rd, er);
        #1 chk(signal_strength_probe === 1'b0, "probe off");
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, CFG0_ADDR, 32'(d << DIV_SEL_POS), rd, er);
            repeat (3) wait_on(3, 1'b1, 30, n);
            chk(n === int'(d ? DIV_HI : DIV_LO), "divide");
        end
        apb(1'b1, CFG0_ADDR, 32'h20, rd, er);
        repeat (4) @(posedge pclk);
        #1 chk(power_step_pin_oe === 1'b0, "step waits");
        set_sel(1'b0);
        wait_on(0, 1'b1, PA_ON_CYC + 10, n);
        chk(n >= PA_ON_CYC && n <= PA_ON_CYC + 4, "amp delay");
        chk(pa_powered === 1'b1, "pa powered");
        chk(power_step_wire === 1'b0 && rx_mode === 1'b0, "slot");
        apb(1'b1, CFG0_ADDR, 32'h0, rd, er);
        #1 chk(power_step_pin_oe === 1'b1, "step kept");
        set_sel(1'b1);
        wait_on(0, 1'b0, 20, n);
        chk(n <= PA_OFF_CYC, "amp drop");
        wait_on(1, 1'b1, RECAL_CYC + 10, m);
        chk(n + m >= RECAL_CYC && n + m <= RECAL_CYC + 4, "recal");
        wait_on(2, 1'b1, RX_CYC + 10, k);
        chk(n + m + k >= RX_CYC && n + m + k <= RX_CYC + 4, "rx");
        set_sel(1'b0);
        wait_on(0, 1'b1, PA_ON_CYC + 10, n);
        chk(power_step_wire === 1'b1, "step released");
        @(posedge pclk);
        pll_lock_in <= 1'b0;
        wait_on(0, 1'b0, 8, n);
        chk(amp_enable_out === 1'b0, "lock fault");
        @(posedge pclk);
        pll_lock_in <= 1'b1;
        repeat (20) @(posedge pclk);
        #1 chk(amp_enable_out === 1'b0, "fault latched");
        apb(1'b0, STAT_ADDR, 32'h0, rd, er);
        chk(rd === 32'h20 && er === 1'b0, "status");
        set_sel(1'b1);
        repeat (10) @(posedge pclk);
        set_sel(1'b0);
        wait_on(0, 1'b1, PA_ON_CYC + 10, n);
        chk(amp_enable_out === 1'b1, "next slot");
        set_sel(1'b1);
        repeat (10) @(posedge pclk);
        set_sel(1'b0);
        @(posedge pclk);
        supply_low_in <= 1'b1;
        repeat (5) @(posedge pclk);
        supply_low_in <= 1'b0;
        wait_on(0, 1'b1, PA_ON_CYC + 10, n);
        chk(amp_enable_out === 1'b0, "supply fault");
        print_verdict();
    end
endmodule // tb_top
